//--- verilog/general_timer_cfg.svh
`ifndef GENERAL_TIMER_CFG_SVH
`define GENERAL_TIMER_CFG_SVH
// register byte offsets
`define OFS_MODE34      8'h1C
`define OFS_ENABLE      8'h20
`define OFS_COUNT       8'h24
`define OFS_DIVIDER     8'h2C
`define OFS_RELOAD      8'h28
`define OFS_CMP1        8'h34
`define OFS_CMP2        8'h38
`define OFS_CMP3        8'h3C
`define OFS_CMP4        8'h40
`define OFS_DEADTIME    8'h44
`define OFS_BURST_CFG   8'h48
`define OFS_BURST_PORT  8'h4C
// writable bit masks
`define MASK_ENABLE     16'h3333
`define MASK_DEADTIME   16'hFF3F
`define MASK_BURST_CFG  16'h1F1F
// reset values
`define RST_RELOAD      16'hFFFF
`define RST_ZERO16      16'h0000
// field positions and codes
`define LEVEL_BIT       16
`define DIR_OUTPUT      2'h0
`define MODE_PWM1       3'h6
`define MODE_PWM2       3'h7
`endif

//--- verilog/general_timer_pkg.sv
package general_timer_pkg;
	// pwm pair generator states
	typedef enum logic [1:0] {
		DT_IDLE = 2'b00,
		DT_WAIT = 2'b01,
		DT_RUN  = 2'b10
	} dt_state_t;
	// whole block state
	typedef struct packed {
		logic [15:0]      mode34;
		logic [15:0]      enable;
		logic [15:0]      count;
		logic [15:0]      divider;
		logic [15:0]      div_cnt;
		logic [15:0]      reload;
		logic [3:0][15:0] cmp;
		logic [3:0]       level;
		logic [3:0][2:0]  cap_edge_cnt;
		logic [3:0]       in_s1;
		logic [3:0]       in_s2;
		logic [3:0]       in_prev;
		logic [15:0]      deadtime;
		logic [15:0]      burst_cfg;
		logic [15:0]      burst_port;
		logic [4:0]       burst_idx;
		logic [1:0][3:0]  dt_cnt;
		logic [1:0]       ref_prev;
		logic [3:0]       pin;
		logic [31:0]      prdata;
	} state_t;
endpackage : general_timer_pkg

//--- verilog/general_timer.sv
// What this block does
// - output polarity one means active low
// - input polarity one captures falling edge
// - output enable drives reference to pin
// - input enable allows counter capture
// - counter readable writable, resets zero
// - count clock is divided by divider+1
// - reload loaded each period, resets ones
// - reload zero stops the counter
// - compare value low half, level bit 16
// - dead time is field plus one clocks
// - four complementary polarity bits
// - ch2 pair enables dead time, ch4 complement
// - ch1 pair enables dead time, ch3 complement
// - burst length is field plus one
// - burst base is a word offset from address zero
// - burst port is dma access address
// - enable register bit layout per channel
// - output mode field layout ch3 ch4
// - input filter divider layout ch3 ch4
// - codes 110 111 are pwm modes
// - input divider 1 2 4 8 events
// - direction 00 output, others input
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "general_timer_cfg.svh"
module general_timer (
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// channel pins
	input  wire logic [3:0]  ch_in,
	output logic [3:0]       ch_out,
	output logic [3:0]       ch_out_en
);
	general_timer_pkg::state_t q;   // registered state
	general_timer_pkg::state_t d;   // next state
	logic        wr;                // write taken this edge
	logic        rd;                // read taken this edge
	logic [7:0]  eaddr;             // effective address
	logic        mapped;            // address decodes
	logic [31:0] rdata;             // read mux
	logic        tick;              // divided count clock
	logic [3:0]  refs;              // reference levels
	logic [3:0]  is_out;            // channel is output
	logic [3:0]  edge_hit;          // selected edge seen
	logic [1:0]  ch_div [4];        // input divider code
	logic [2:0]  ch_mode [4];       // output mode code

	// bus handshake, single wait-free access
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr      = psel & penable & pwrite & mapped & clk_en;
	assign rd      = psel & penable & ~pwrite & mapped & clk_en;
	assign prdata  = q.prdata;

	// burst port redirects to base plus index
	always_comb begin
		if (paddr == `OFS_BURST_PORT)
			eaddr = 8'(({3'h0, q.burst_cfg[4:0]} + {3'h0, q.burst_idx}) << 2);
		else
			eaddr = paddr;
	end

	// per-channel fields
	always_comb begin
		ch_mode[0] = 3'h0;
		ch_mode[1] = 3'h0;
		ch_mode[2] = q.mode34[6:4];
		ch_mode[3] = q.mode34[14:12];
		ch_div[0]  = 2'h0;
		ch_div[1]  = 2'h0;
		ch_div[2]  = q.mode34[3:2];
		ch_div[3]  = q.mode34[11:10];
		is_out[0]  = 1'b1;
		is_out[1]  = 1'b1;
		is_out[2]  = q.mode34[1:0] == `DIR_OUTPUT;
		is_out[3]  = q.mode34[9:8] == `DIR_OUTPUT;
	end

	// reference generation, upcounting pwm
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (ch_mode[i] == `MODE_PWM1)
				refs[i] = q.count < q.cmp[i];
			else if (ch_mode[i] == `MODE_PWM2)
				refs[i] = !(q.count < q.cmp[i]);
			else
				refs[i] = 1'b0;
			// polarity-adjusted edge of the synced input
			edge_hit[i] = q.enable[4*i+1] ? (q.in_prev[i] & ~q.in_s2[i])
			                             : (~q.in_prev[i] & q.in_s2[i]);
		end
	end

	// read mux, reserved bits zero
	always_comb begin
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		case (eaddr)
			`OFS_MODE34:     rdata = {16'h0000, q.mode34};
			`OFS_ENABLE:     rdata = {16'h0000, q.enable};
			`OFS_COUNT:      rdata = {16'h0000, q.count};
			`OFS_DIVIDER:    rdata = {16'h0000, q.divider};
			`OFS_RELOAD:     rdata = {16'h0000, q.reload};
			`OFS_CMP1:       rdata = {15'h0000, q.level[0], q.cmp[0]};
			`OFS_CMP2:       rdata = {15'h0000, q.level[1], q.cmp[1]};
			`OFS_CMP3:       rdata = {15'h0000, q.level[2], q.cmp[2]};
			`OFS_CMP4:       rdata = {15'h0000, q.level[3], q.cmp[3]};
			`OFS_DEADTIME:   rdata = {16'h0000, q.deadtime};
			`OFS_BURST_CFG:  rdata = {16'h0000, q.burst_cfg};
			default:         mapped = 1'b0;
		endcase
	end

	assign tick = (q.div_cnt == q.divider);

	// next state
	always_comb begin
		d = q;
		// read word taken in the setup cycle, so it stands at the access edge
		d.prdata = (psel && !penable) ? rdata : q.prdata;
		// pin synchronisers
		d.in_s1   = ch_in;
		d.in_s2   = q.in_s1;
		d.in_prev = q.in_s2;
		// prescaler and counter
		d.div_cnt = tick ? 16'h0000 : 16'(q.div_cnt + 16'h0001);
		if (tick && q.reload != `RST_ZERO16) begin
			if (q.count >= q.reload)
				d.count = `RST_ZERO16;
			else
				d.count = 16'(q.count + 16'h0001);
		end
		// captures
		for (int i = 0; i < 4; i++) begin
			if (!is_out[i] && q.enable[4*i] && edge_hit[i]) begin
				d.cap_edge_cnt[i] = 3'(q.cap_edge_cnt[i] + 3'h1);
				if ((q.cap_edge_cnt[i] & 3'((4'h1 << ch_div[i]) - 4'h1)) == 3'h0) begin
					d.cmp[i]   = q.count;
					d.level[i] = q.in_s2[i];
				end
			end
			if (!q.enable[4*i])
				d.cap_edge_cnt[i] = 3'h0;
		end
		// outputs with polarity and enable
		for (int i = 0; i < 4; i++)
			d.pin[i] = q.enable[4*i] & (refs[i] ^ q.enable[4*i+1]);
		// dead-time pairs: ch1 with ch3, ch2 with ch4
		for (int p = 0; p < 2; p++) begin
			d.ref_prev[p] = refs[p];
			if (refs[p] != q.ref_prev[p])
				d.dt_cnt[p] = q.deadtime[8+4*p +: 4];
			else if (q.dt_cnt[p] != 4'h0)
				d.dt_cnt[p] = 4'(q.dt_cnt[p] - 4'h1);
			if (q.deadtime[p]) begin
				// both sides at their polarity level (inactive) while the delay runs
				d.pin[p]   = (refs[p] & (q.dt_cnt[p] == 4'h0) & (refs[p] == q.ref_prev[p]))
				             ^ q.deadtime[2+2*p];
				d.pin[p+2] = (~refs[p] & (q.dt_cnt[p] == 4'h0) & (refs[p] == q.ref_prev[p]))
				             ^ q.deadtime[3+2*p];
			end
		end
		// register writes
		if (wr) begin
			case (eaddr)
				`OFS_MODE34:    d.mode34    = pwdata[15:0];
				`OFS_ENABLE:    d.enable    = pwdata[15:0] & `MASK_ENABLE;
				`OFS_COUNT:     d.count     = pwdata[15:0];
				`OFS_DIVIDER:   d.divider   = pwdata[15:0];
				`OFS_RELOAD:    d.reload    = pwdata[15:0];
				`OFS_CMP1:      d.cmp[0]    = pwdata[15:0];
				`OFS_CMP2:      d.cmp[1]    = pwdata[15:0];
				`OFS_CMP3:      d.cmp[2]    = pwdata[15:0];
				`OFS_CMP4:      d.cmp[3]    = pwdata[15:0];
				`OFS_DEADTIME:  d.deadtime  = pwdata[15:0] & `MASK_DEADTIME;
				`OFS_BURST_CFG: d.burst_cfg = pwdata[15:0] & `MASK_BURST_CFG;
				default:        d.burst_port = q.burst_port;
			endcase
		end
		// burst index walks one register per access
		if ((wr || rd) && paddr == `OFS_BURST_PORT) begin
			d.burst_port = wr ? pwdata[15:0] : q.burst_port;
			if (q.burst_idx >= q.burst_cfg[12:8])
				d.burst_idx = 5'h00;
			else
				d.burst_idx = 5'(q.burst_idx + 5'h01);
		end
		if (wr && paddr == `OFS_BURST_CFG)
			d.burst_idx = 5'h00;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q        <= '0;
			q.reload <= `RST_RELOAD;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// pins
	assign ch_out    = q.pin;
	assign ch_out_en = is_out & {q.enable[12], q.enable[8], q.enable[4], q.enable[0]};

	// checks, all on the bus clock
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// capture on a selected ch4 edge, divider one
	sequence s_cap4_edge;
		clk_en && !is_out[3] && q.enable[12] && q.mode34[11:10] == 2'h0 && edge_hit[3] && !wr;
	endsequence
	// count and pin level land in the ch4 word
	sequence s_cap4_stored;
		q.cmp[3] == $past(q.count) && q.level[3] == $past(q.in_s2[3]);
	endsequence
	// a read set up on the ch1 word
	sequence s_cmp1_setup;
		clk_en && psel && !penable && eaddr == `OFS_CMP1;
	endsequence
	// reserved bits and level bit of that read
	sequence s_cmp1_answer;
		prdata[31:17] == 15'h0000 && prdata[16] == $past(q.level[0]);
	endsequence

	// count frozen while reload is zero
	a_reload_zero_hold: assert property (
		clk_en && q.reload == 16'h0000 && !wr |=> $stable(q.count))
		else $error("count moved with reload zero");
	// active high ch1 follows its reference
	a_out_polarity: assert property (
		clk_en && !q.deadtime[0] && q.enable[0] && !q.enable[1] |=> ch_out[0] == $past(refs[0]))
		else $error("active high output wrong");
	// disabled ch4 stays low
	a_out_disabled: assert property (
		clk_en && !q.enable[12] && !q.deadtime[1] |=> !ch_out[3])
		else $error("disabled channel drives");
	// reserved top bits of enable and burst setup never set
	a_reserved_zero: assert property (
		q.enable[15:14] == 2'h0 && q.burst_cfg[15:13] == 3'h0)
		else $error("reserved bits set");
	// level bit sits at bit 16 of the read word
	a_level_bit: assert property (
		s_cmp1_setup |=> s_cmp1_answer)
		else $error("level bit misplaced");
	// software write reaches the counter
	a_count_write: assert property (
		wr && eaddr == `OFS_COUNT |=> q.count == $past(pwdata[15:0]))
		else $error("count write lost");
	// burst index never passes the length
	a_burst_wrap: assert property (
		q.burst_idx <= q.burst_cfg[12:8] || $past(wr))
		else $error("burst index beyond length");
	// prescaler restarts after each tick
	a_prescale_tick: assert property (
		clk_en && tick && q.divider != 16'h0000 |=> q.div_cnt == 16'h0000 ##1 (!tick || !clk_en))
		else $error("prescaler restart wrong");

	// enable write keeps only the defined bits
	a_enable_mask: assert property (
		wr && eaddr == `OFS_ENABLE |=> q.enable == ($past(pwdata[15:0]) & `MASK_ENABLE))
		else $error("enable write mask wrong");
	// dead-time write keeps only the defined bits
	a_deadtime_mask: assert property (
		wr && eaddr == `OFS_DEADTIME |=> q.deadtime == ($past(pwdata[15:0]) & `MASK_DEADTIME))
		else $error("dead time write mask wrong");
	// new burst setup restarts the walk
	a_burst_restart: assert property (
		wr && paddr == `OFS_BURST_CFG |=> q.burst_idx == 5'h00)
		else $error("burst index not restarted");
	// each port access below the length moves one register on
	a_burst_step: assert property (
		(wr || rd) && paddr == `OFS_BURST_PORT && q.burst_idx < q.burst_cfg[12:8]
		|=> q.burst_idx == 5'($past(q.burst_idx) + 5'h01))
		else $error("burst index did not advance");
	// end of period returns the count to zero
	a_count_wrap: assert property (
		clk_en && tick && q.reload != 16'h0000 && q.count >= q.reload && !wr
		|=> q.count == 16'h0000)
		else $error("count did not wrap");
	// count moves only on a divided tick
	a_count_hold: assert property (
		clk_en && !tick && !wr |=> $stable(q.count))
		else $error("count moved between ticks");
	// no capture while ch4 is disabled
	a_capture_blocked: assert property (
		clk_en && !q.enable[12] && !wr |=> $stable(q.cmp[3]))
		else $error("capture while disabled");
	// enabled edge stores count and level
	a_capture_store: assert property (
		s_cap4_edge |=> s_cap4_stored)
		else $error("capture not stored");

	// input ch4 never drives its pin
	a_input_undriven: assert property (
		q.mode34[9:8] != 2'h0 |-> !ch_out_en[3])
		else $error("input channel drives");
	// disabled ch3 never drives its pin
	a_ch3_undriven: assert property (
		!q.enable[8] |-> !ch_out_en[2])
		else $error("disabled ch3 drives");
	// first pwm mode active below compare
	a_pwm1_active: assert property (
		clk_en && !q.deadtime[0] && q.mode34[6:4] == `MODE_PWM1 && q.enable[9:8] == 2'h1
		&& q.count < q.cmp[2] |=> ch_out[2])
		else $error("pwm1 level wrong");
	// second pwm mode inactive below compare
	a_pwm2_inactive: assert property (
		clk_en && !q.deadtime[0] && q.mode34[6:4] == `MODE_PWM2 && q.enable[9:8] == 2'h1
		&& q.count < q.cmp[2] |=> !ch_out[2])
		else $error("pwm2 level wrong");
	// polarity set drives the active level low
	a_polarity_low: assert property (
		clk_en && !q.deadtime[0] && q.mode34[6:4] == `MODE_PWM1 && q.enable[9:8] == 2'h3
		&& q.count < q.cmp[2] |=> !ch_out[2])
		else $error("active low output wrong");
	// settled pair with equal polarity is complementary
	a_complement_pair: assert property (
		clk_en && q.deadtime[0] && q.deadtime[2] == q.deadtime[3] && q.dt_cnt[0] == 4'h0
		&& refs[0] == q.ref_prev[0] |=> ch_out[0] != ch_out[2])
		else $error("pair not complementary");
	// read word of the enable register has zero upper bits
	a_setup_reserved: assert property (
		clk_en && psel && !penable && eaddr == `OFS_ENABLE |=> prdata[31:14] == 18'h00000)
		else $error("reserved read bits set");
	// divider write lands
	a_divider_write: assert property (
		wr && eaddr == `OFS_DIVIDER |=> q.divider == $past(pwdata[15:0]))
		else $error("divider write lost");
	// mode write lands whole
	a_mode_write: assert property (
		wr && eaddr == `OFS_MODE34 |=> q.mode34 == $past(pwdata[15:0]))
		else $error("mode write lost");
endmodule : general_timer

//--- tb/tb.sv
`timescale 1ns/100ps
`include "general_timer_cfg.svh"
module tb;
	// clock, reset, run control
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	// apb request and answer
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// channel pins
	logic [3:0]  ch_in;
	logic [3:0]  ch_out;
	logic [3:0]  ch_out_en;
	// bookkeeping
	int          failures;
	int          total_checks;
	int          cycles;
	logic [31:0] rd_q;
	logic        err_q;
	logic [15:0] cap_q;

	general_timer general_timer_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch_in(ch_in), .ch_out(ch_out), .ch_out_en(ch_out_en));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; answer taken at the edge where ready is high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) begin
			failures++;
			$display("mismatch at %0t: no ready", $time);
		end
		err_q = pslverr;
		rd_q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// pins are registered: look half a clock later
	task settle;
		@(negedge pclk);
	endtask : settle

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_q, e);
	endtask : rd

	task t_reset;
		rd(`OFS_RELOAD, 32'h0000FFFF);
		rd(`OFS_ENABLE, 32'h0);
		rd(`OFS_CMP1, 32'h0);
		rd(`OFS_DEADTIME, 32'h0);
		rd(`OFS_MODE34, 32'h0);
		$display("reset values done");
	endtask : t_reset

	// all ones written, reserved bits must come back zero
	task t_masks;
		wr(`OFS_ENABLE, 32'hFFFFFFFF);
		rd(`OFS_ENABLE, 32'h00003333);
		wr(`OFS_DEADTIME, 32'hFFFFFFFF);
		rd(`OFS_DEADTIME, 32'h0000FF3F);
		wr(`OFS_BURST_CFG, 32'hFFFFFFFF);
		rd(`OFS_BURST_CFG, 32'h00001F1F);
		wr(`OFS_CMP1, 32'hFFFFFFFF);
		rd(`OFS_CMP1, 32'h0000FFFF);
		chk({31'h0, err_q}, 32'h0);
		wr(8'h50, 32'h1);
		chk({31'h0, err_q}, 32'h1);
		wr(`OFS_ENABLE, 32'h0);
		wr(`OFS_DEADTIME, 32'h0);
		$display("masks done");
	endtask : t_masks

	task t_count;
		wr(`OFS_RELOAD, 32'h0);
		wr(`OFS_COUNT, 32'h5);
		repeat (20) @(posedge pclk);
		rd(`OFS_COUNT, 32'h5);
		wr(`OFS_RELOAD, 32'hFFFF);
		wr(`OFS_DIVIDER, 32'h3);
		wr(`OFS_COUNT, 32'h0);
		repeat (40) @(posedge pclk);
		apb(1'b0, `OFS_COUNT, 32'h0);
		chk({31'h0, rd_q[15:0] >= 16'h0009 && rd_q[15:0] <= 16'h000C}, 32'h1);
		$display("counter done");
	endtask : t_count

	// ch3 output: cmp above count keeps the reference active in pwm1, inactive in pwm2
	task t_pwm;
		wr(`OFS_CMP3, 32'hFFFF);
		wr(`OFS_MODE34, 32'h0060);
		wr(`OFS_ENABLE, 32'h0100);
		settle;
		chk({30'h0, ch_out_en[2], ch_out[2]}, 32'h3);
		wr(`OFS_ENABLE, 32'h0300);
		settle;
		chk({30'h0, ch_out_en[2], ch_out[2]}, 32'h2);
		wr(`OFS_MODE34, 32'h0070);
		settle;
		chk({30'h0, ch_out_en[2], ch_out[2]}, 32'h3);
		wr(`OFS_ENABLE, 32'h0);
		settle;
		chk({31'h0, ch_out_en[2]}, 32'h0);
		$display("pwm done");
	endtask : t_pwm

	// complementary pairs; one-clock dead time is shorter than any level
	task t_dead;
		wr(`OFS_DEADTIME, 32'h00000003);
		repeat (4) @(posedge pclk);
		settle;
		chk({28'h0, ch_out}, 32'h0000000C);
		wr(`OFS_DEADTIME, 32'h0000003F);
		repeat (4) @(posedge pclk);
		settle;
		chk({28'h0, ch_out}, 32'h00000003);
		wr(`OFS_DEADTIME, 32'h0);
		$display("dead time done");
	endtask : t_dead

	// ch4 as input: blocked, rising, then falling capture
	task t_capture;
		wr(`OFS_MODE34, 32'h0100);
		wr(`OFS_CMP4, 32'h1234);
		ch_in[3] <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(`OFS_CMP4, 32'h1234);
		chk({31'h0, ch_out_en[3]}, 32'h0);
		ch_in[3] <= 1'b0;
		wr(`OFS_ENABLE, 32'h1000);
		ch_in[3] <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, `OFS_CMP4, 32'h0);
		cap_q = rd_q[15:0];
		chk({30'h0, rd_q[16], cap_q !== 16'h1234}, 32'h3);
		wr(`OFS_ENABLE, 32'h3000);
		ch_in[3] <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, `OFS_CMP4, 32'h0);
		chk({30'h0, rd_q[16], rd_q[15:0] !== cap_q}, 32'h1);
		$display("capture done");
	endtask : t_capture

	// base 0x0D is the cmp1 word, two transfers then wrap
	task t_burst;
		wr(`OFS_CMP1, 32'h1111);
		wr(`OFS_CMP2, 32'h2222);
		wr(`OFS_BURST_CFG, 32'h010D);
		rd(`OFS_BURST_PORT, 32'h1111);
		rd(`OFS_BURST_PORT, 32'h2222);
		rd(`OFS_BURST_PORT, 32'h1111);
		$display("burst done");
	endtask : t_burst

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			$display("mismatch at %0t: timeout", $time);
			end_of_test;
		end
	end

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ch_in} = '0;
		clk_en = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_masks;
		t_count;
		t_pwm;
		t_dead;
		t_capture;
		t_burst;
		end_of_test;
	end
endmodule : tb
